/* File: periodic_timer.sv */
// periodic timer: timer/counter, pwm, single pulse and capture modes
// assumes pins synchronous to pclk and one timer tick per pclk edge
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

// Functional notes
// R1: mode 11 plain timer, pin unused
// R2: mode 10 pwm, period clears, duty sets active
// R3: period 0 gives 65536 clocks
// R4: duty at or above period gives 100%
// R5: pwm raises duty and period flags
// R6: level, pin action and invert shape pin
// R7: counter runs with pin forced
// R8: clear select ignored in pwm
// R9: mode 10 with action 11 is pulse
// R10: run rise starts pulse, ext pin sets run
// R11: pulse ends on run clear or duty match
// R12: pulse counter cleared only by run rise
// R13: mode 01 capture, source select, run starts
// R14: edge select, action 11 means no capture
// R15: selected edge latches counter, raises flag
// R16: period match clears counter in capture
// R17: capture clear 01 rising, 10 falling
// R18: clear field 00 latches into a only
// R19: software must not share ext pin roles
// R20: pulses under two clocks may be missed
// R21: latch within 1.5 clocks, flag after
// R22: capture clear 11 clears on both edges
// R23: latch edge flag shows last edge
module periodic_timer (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire periodic_timer_pkg::apb_req_s apb_req,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire logic                         capture_pin,
  input  wire logic                         ext_clock_pin,
  output logic                              pin_out,
  output logic                              pin_oe_n
);
  import periodic_timer_pkg::*;

  // registers
  ctrl_s       ctrl_q;        // control fields
  logic        run_q;         // timer_run
  logic        run_prev_q;    // run one cycle ago, for the rising edge
  logic [15:0] cnt_q;         // free running counter
  logic [15:0] duty_q;        // duty_compare_value, also capture a
  logic [15:0] capb_q;        // second_capture_value
  logic [15:0] per_q;         // period_compare_value
  logic        duty_f_q;      // duty_match_flag
  logic        per_f_q;       // period_match_flag
  logic        edge_q;        // latch_edge_flag
  logic        cap_pend_q;    // capture done, flag due next edge
  logic        src_prev_q;    // selected capture source one cycle ago
  logic        ext_prev_q;    // ext clock pin one cycle ago
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        pin_out_q;
  logic        pin_oe_n_q;

  // apb decode
  wire         acc_phase = apb_req.psel & apb_req.penable;
  wire         xfer_done = acc_phase & pready_q;        // write lands here only
  wire         wr_en     = xfer_done & apb_req.pwrite;
  wire         sel_ctrl  = (apb_req.paddr == OFF_CTRL);
  wire         sel_stat  = (apb_req.paddr == OFF_STAT);
  wire         sel_cnt   = (apb_req.paddr == OFF_CNT);
  wire         sel_duty  = (apb_req.paddr == OFF_DUTY);
  wire         sel_capb  = (apb_req.paddr == OFF_CAPB);
  wire         sel_per   = (apb_req.paddr == OFF_PER);
  wire         mapped    = sel_ctrl | sel_stat | sel_cnt | sel_duty | sel_capb | sel_per;
  wire         wr_ctrl   = wr_en & sel_ctrl;
  wire         wr_stat   = wr_en & sel_stat;
  wire         wr_duty   = wr_en & sel_duty;
  wire         wr_capb   = wr_en & sel_capb;
  wire         wr_per    = wr_en & sel_per;

  // read mux, chained by address
  wire [31:0]  rd_mux =
    sel_ctrl ? {20'h00000, ctrl_q, run_q} :
    sel_stat ? {29'h00000000, edge_q, per_f_q, duty_f_q} :
    sel_cnt  ? {16'h0000, cnt_q} :
    sel_duty ? {16'h0000, duty_q} :
    sel_capb ? {16'h0000, capb_q} :
    sel_per  ? {16'h0000, per_q} : DATA_RST;

  // operating mode decode
  op_e op;
  assign op = (ctrl_q.mode_sel == MODE_CAP) ? OP_CAP :                             // R13
              (ctrl_q.mode_sel == MODE_TMR) ? OP_TMR :                             // R1
              (ctrl_q.mode_sel == MODE_PWM) ?
                ((ctrl_q.pin_action == PA_PULSE) ? OP_SPO : OP_PWM) : OP_CMP;    // R9

  // comparator hits on the last count of a span; a period of zero wraps at ffff
  wire [15:0]  per_m1   = per_q - 16'h0001;
  wire [15:0]  duty_m1  = duty_q - 16'h0001;
  wire         run_rise = run_q & ~run_prev_q;
  wire         p_hit    = run_q & ~run_rise & (cnt_q == per_m1);                  // R3 R16
  wire         a_hit    = run_q & ~run_rise & (duty_q != VAL_RST) & (cnt_q == duty_m1);

  // capture source and its edges; the pins are taken as already synchronous
  wire         src      = ctrl_q.capture_source_select ? ext_clock_pin : capture_pin; // R13
  // no width filter: a pulse under two clocks is still seen, which the rules allow
  wire         src_rise = src & ~src_prev_q;                                      // R20
  wire         src_fall = ~src & src_prev_q;
  wire         ext_rise = ext_clock_pin & ~ext_prev_q;

  // active edge choice by pin action
  wire         edge_sel =
    (ctrl_q.pin_action == EDGE_RISE) ? src_rise :
    (ctrl_q.pin_action == EDGE_FALL) ? src_fall :
    (ctrl_q.pin_action == EDGE_BOTH) ? (src_rise | src_fall) : 1'b0;             // R14
  wire         cap_hit  = (op == OP_CAP) & run_q & edge_sel;                      // R15
  // with clear field 00 everything goes to a; otherwise falling edges go to b
  wire         cap_to_b = cap_hit & (ctrl_q.capture_clear != CLR_NONE) & src_fall; // R18
  wire         cap_to_a = cap_hit & ~cap_to_b;

  // selected capture source edges that also clear the counter, independent of edge choice
  wire         clr_edge =
    (ctrl_q.capture_clear == CLR_RISE) ? src_rise :                               // R17
    (ctrl_q.capture_clear == CLR_FALL) ? src_fall :                               // R17
    (ctrl_q.capture_clear == CLR_BOTH) ? (src_rise | src_fall) : 1'b0;           // R22

  // counter clear per mode
  wire         cmp_clr  = ctrl_q.counter_clear_select ? a_hit : p_hit;            // R1
  wire         cnt_clr  =
    ((op == OP_CMP) | (op == OP_TMR)) ? cmp_clr :                                 // R1
    (op == OP_PWM) ? p_hit :                                                      // R2 R8
    (op == OP_CAP) ? (p_hit | (run_q & clr_edge)) :                               // R16 R17
    1'b0;                                                                         // R12

  // flag set terms
  wire         duty_set =
    (op == OP_CAP) ? cap_pend_q : a_hit;                                          // R5 R11 R21
  wire         per_set  =
    ((op == OP_CMP) | (op == OP_TMR)) ? (p_hit & ~ctrl_q.counter_clear_select) :
    (op == OP_SPO) ? 1'b0 : p_hit;                                                // R5 R16

  // run bit: software write first, then ext trigger, then pulse end
  wire         spo_end  = (op == OP_SPO) & a_hit;                                 // R11
  wire         ext_set  = (op == OP_SPO) & ctrl_q.ext_trig_en & ext_rise;        // R10
  wire         run_d    = wr_ctrl ? apb_req.pwdata[RUN_BIT] :
                          ext_set ? 1'b1 :
                          spo_end ? 1'b0 : run_q;

  // counter: held while stopped, zeroed on run rise
  wire [15:0]  cnt_d    = ~run_q            ? cnt_q :
                          (run_rise | cnt_clr) ? VAL_RST :                        // R10 R12
                          cnt_q + 16'h0001;                                       // R7 R15

  // pwm waveform, full duty when duty reaches the period
  wire         full_duty = (per_q != VAL_RST) & (duty_q >= per_q);               // R4
  wire         pwm_raw   = run_q & (full_duty | (cnt_q < duty_q));               // R2
  // pulse is active for as long as run stays high
  wire         spo_raw   = run_q;                                                 // R10 R11
  wire         wave_raw  = (op == OP_SPO) ? spo_raw : pwm_raw;
  // level control picks active high or low
  wire         wave_lvl  = ctrl_q.output_level_ctrl ? wave_raw : ~wave_raw;      // R6
  wire         pin_lvl   =
    (op == OP_CMP) ? ctrl_q.output_level_ctrl :
    (ctrl_q.pin_action == PA_LOW)  ? 1'b0 :                                       // R6
    (ctrl_q.pin_action == PA_HIGH) ? 1'b1 : wave_lvl;                            // R6
  wire         pin_d     = pin_lvl ^ ctrl_q.output_invert;                        // R6
  // pin is released in timer and capture modes for other pin functions
  wire         pin_oe_n_d = (op == OP_TMR) | (op == OP_CAP);                      // R1

  // flags: hardware set wins over a same cycle write-one clear
  wire         duty_f_d = duty_set | (duty_f_q & ~(wr_stat & apb_req.pwdata[STAT_DUTY]));
  wire         per_f_d  = per_set | (per_f_q & ~(wr_stat & apb_req.pwdata[STAT_PER]));

  // apb slave: one wait state, read data and error ready with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= DATA_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_phase & ~pready_q;
      prdata_q  <= (acc_phase & ~pready_q & ~apb_req.pwrite) ? rd_mux : DATA_RST;
      pslverr_q <= acc_phase & ~pready_q & ~mapped;
    end
  end

  // control and run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= CTRL_RST;
      run_q      <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_s'(apb_req.pwdata[CTRL_MSB:CTRL_LSB]);
      end
      run_q      <= run_d;
      run_prev_q <= run_q;
    end
  end

  // counter and input edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= VAL_RST;
      src_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      src_prev_q <= src;
      ext_prev_q <= ext_clock_pin;
    end
  end

  // comparators and capture registers; a capture beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= VAL_RST;
      capb_q <= VAL_RST;
      per_q  <= VAL_RST;
    end else begin
      if (cap_to_a) begin
        duty_q <= cnt_q;                                                          // R15 R21
      end else if (wr_duty) begin
        duty_q <= apb_req.pwdata[15:0];
      end
      if (cap_to_b) begin
        capb_q <= cnt_q;                                                          // R15
      end else if (wr_capb) begin
        capb_q <= apb_req.pwdata[15:0];
      end
      if (wr_per) begin
        per_q <= apb_req.pwdata[15:0];
      end
    end
  end

  // flags; the capture flag follows the latch by one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_f_q   <= 1'b0;
      per_f_q    <= 1'b0;
      edge_q     <= 1'b0;
      cap_pend_q <= 1'b0;
    end else begin
      duty_f_q   <= duty_f_d;
      per_f_q    <= per_f_d;
      cap_pend_q <= cap_hit;                                                      // R21
      if (cap_hit) begin
        edge_q <= src_rise;                                                       // R23
      end
    end
  end

  // output pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_out_q  <= pin_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign pready   = pready_q;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign pin_out  = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;

  // checks on the mode logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  timer_pin_off_a: assert property ((op == OP_TMR) && !wr_ctrl |=> pin_oe_n_q) // R1
    else $error("pin driven in timer mode");

  pwm_period_a: assert property ((op == OP_PWM) && p_hit && !wr_ctrl |=> cnt_q == 16'h0000) // R2
    else $error("pwm counter not cleared by period match");

  pwm_wrap_a: assert property ((op == OP_PWM) && run_q && !run_rise && per_q == 16'h0000
      && cnt_q == 16'hffff && !wr_ctrl |=> cnt_q == 16'h0000 && per_f_q) // R3
    else $error("zero period did not give 65536 clocks");

  full_duty_a: assert property ((op == OP_PWM) && ctrl_q.pin_action == PA_WAVE && run_q
      && full_duty && !wr_ctrl |=> pin_out_q == ($past(ctrl_q.output_level_ctrl)
      ^ $past(ctrl_q.output_invert))) // R4
    else $error("full duty did not hold pin active");

  pwm_duty_flag_a: assert property ((op == OP_PWM) && a_hit |=> duty_f_q) // R5
    else $error("duty match flag missing in pwm");

  pwm_forced_run_a: assert property ((op == OP_PWM) && ctrl_q.pin_action == PA_LOW && run_q
      && !run_rise && !p_hit && !wr_ctrl |=> cnt_q == $past(cnt_q) + 16'h0001) // R7
    else $error("pwm counter stopped while pin forced");

  pulse_end_a: assert property ((op == OP_SPO) && a_hit && !wr_ctrl && !ext_set |=> !run_q
      ##1 (!run_q || $past(wr_ctrl) || $past(ext_set))) // R11
    else $error("duty match did not end single pulse");

  pulse_no_clear_a: assert property ((op == OP_SPO) && run_q && !run_rise && !wr_ctrl
      && cnt_q != 16'hffff |=> cnt_q != 16'h0000) // R12
    else $error("single pulse counter cleared without run rise");

  cap_latch_a: assert property (cap_to_a |=> duty_q == $past(cnt_q) ##1 duty_f_q) // R15 R21
    else $error("capture did not latch counter then flag");

  cap_none_a: assert property ((op == OP_CAP) && ctrl_q.pin_action == EDGE_NONE && !wr_ctrl
      |=> !cap_pend_q) // R14
    else $error("capture taken with edge select off");

  latch_edge_a: assert property (cap_hit && src_rise |=> edge_q) // R23
    else $error("latch edge flag wrong after rising capture");

endmodule

/* File: periodic_timer_pkg.sv */
// constants, codes and carrier types for the periodic timer block
// assumes a 32-bit apb master and a timer tick on every pclk edge
package periodic_timer_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL = 8'h00;  // control word, run bit in bit 0
  localparam logic [7:0] OFF_STAT = 8'h04;  // match flags and latch edge flag
  localparam logic [7:0] OFF_CNT  = 8'h08;  // counter, read only
  localparam logic [7:0] OFF_DUTY = 8'h0c;  // duty comparator / capture register a
  localparam logic [7:0] OFF_CAPB = 8'h10;  // second capture register
  localparam logic [7:0] OFF_PER  = 8'h14;  // period comparator

  // bit positions inside the control and status words
  localparam int RUN_BIT   = 0;   // run bit
  localparam int CTRL_LSB  = 1;   // first bit of the ctrl_s field group
  localparam int CTRL_MSB  = 11;  // last bit of the ctrl_s field group
  localparam int STAT_DUTY = 0;   // duty match flag, write one to clear
  localparam int STAT_PER  = 1;   // period match flag, write one to clear
  localparam int STAT_EDGE = 2;   // latch edge flag, read only

  // mode field codes
  localparam logic [1:0] MODE_CMP = 2'h0;  // compare match output
  localparam logic [1:0] MODE_CAP = 2'h1;  // capture input
  localparam logic [1:0] MODE_PWM = 2'h2;  // pwm or single pulse
  localparam logic [1:0] MODE_TMR = 2'h3;  // plain timer/counter

  // pin action codes in pwm mode
  localparam logic [1:0] PA_LOW   = 2'h0;  // pin forced low
  localparam logic [1:0] PA_HIGH  = 2'h1;  // pin forced high
  localparam logic [1:0] PA_WAVE  = 2'h2;  // pwm waveform on pin
  localparam logic [1:0] PA_PULSE = 2'h3;  // single pulse output

  // pin action codes in capture mode
  localparam logic [1:0] EDGE_RISE = 2'h0;  // capture on rising edges
  localparam logic [1:0] EDGE_FALL = 2'h1;  // capture on falling edges
  localparam logic [1:0] EDGE_BOTH = 2'h2;  // capture on both edges
  localparam logic [1:0] EDGE_NONE = 2'h3;  // no capture, counter still runs

  // capture clear field codes
  localparam logic [1:0] CLR_NONE = 2'h0;  // period match only
  localparam logic [1:0] CLR_RISE = 2'h1;  // plus rising capture edge
  localparam logic [1:0] CLR_FALL = 2'h2;  // plus falling capture edge
  localparam logic [1:0] CLR_BOTH = 2'h3;  // plus either capture edge

  // reset values
  localparam logic [15:0] VAL_RST  = 16'h0000;  // counter and comparators
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // decoded operating mode, one-hot
  typedef enum logic [4:0] {
    OP_CMP = 5'b00001,
    OP_CAP = 5'b00010,
    OP_PWM = 5'b00100,
    OP_SPO = 5'b01000,
    OP_TMR = 5'b10000
  } op_e;

  // software control fields, stored at bits CTRL_MSB..CTRL_LSB
  typedef struct packed {
    logic       ext_trig_en;            // ext clock pin edge may set run (single pulse)
    logic [1:0] capture_clear;          // capture_clear_hi / capture_clear_lo
    logic       counter_clear_select;   // 0 period match, 1 duty match
    logic       capture_source_select;  // 0 capture_pin, 1 ext_clock_pin
    logic       output_invert;          // invert the pin
    logic       output_level_ctrl;      // 1 active high, 0 active low
    logic [1:0] pin_action;             // pin_action_hi / pin_action_lo
    logic [1:0] mode_sel;               // mode_sel_hi / mode_sel_lo
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '0;

  // apb request group from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

/* File: pin_partner.sv */
// model of the pins outside the timer: capture input and trigger pin
// assumes pclk is the timer clock and that calls start just after a rising edge
`timescale 1ns/100ps
module pin_partner (
  input  wire logic pclk,
  output logic      capture_pin,
  output logic      ext_clock_pin
);
  // both pins rest low and are always driven, so no floating level exists
  initial begin
    capture_pin   = 1'b0;
    ext_clock_pin = 1'b0;
  end

  // set one pin, then hold it; a level never lasts under two clocks
  // the trigger pin only carries events here, never the count clock
  task automatic drive(input logic src, input logic lvl, input int n);
    if (src) begin
      ext_clock_pin <= lvl;
    end else begin
      capture_pin <= lvl;
    end
    repeat ((n < 2) ? 2 : n) @(posedge pclk);
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the periodic timer, apb master plus pin model
// assumes one timer tick per pclk edge and the register map of the package
`timescale 1ns/100ps
module testbench;
  import periodic_timer_pkg::*;

  logic        pclk;         // 10 MHz clock
  logic        presetn;      // active low reset
  apb_req_s    req;          // apb request group
  logic        pready;       // apb answer
  logic [31:0] prdata;       // read data
  logic        pslverr;      // unmapped access
  logic        pin_out;      // timer pin level
  logic        pin_oe_n;     // timer pin enable, low drives
  logic        capture_pin;  // from the pin model
  logic        ext_clock_pin;
  logic [31:0] rv;           // last read data
  logic        re;           // last error flag
  logic [31:0] c;            // control word under test
  logic [31:0] a;            // saved capture a
  logic [31:0] bv;           // random write data
  logic [7:0]  offs [6];     // mapped offsets
  int          bad_count;
  int          checked;
  int          seed;
  int          p, d, w1, w2, w3, wd, g;

  periodic_timer periodic_timer_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pin_partner pin_partner_inst (.pclk(pclk), .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin));

  // free-running clock, 100 ns period
  always #50 pclk = ~pclk;

  // verdict and end of run, the only exit
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // compare seen against expected, count both
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= ad;
    req.pwdata  <= dt;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      test_done();
    end else begin
      rv = prdata;
      re = pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // count clocks with the pin high over a window
  task automatic cnt_pin(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin_out === 1'b1) h++;
    end
  endtask

  // control word with the run bit low
  function automatic logic [31:0] cw(logic [1:0] m, logic [1:0] pa, logic lvl, logic inv, logic src,
                                     logic ccs, logic [1:0] cc, logic trg);
    ctrl_s s;
    s = '{ext_trig_en: trg, capture_clear: cc, counter_clear_select: ccs, capture_source_select: src,
          output_invert: inv, output_level_ctrl: lvl, pin_action: pa, mode_sel: m};
    return {20'h0, s, 1'b0};
  endfunction

  function automatic int rnd(int lo, int n);
    return lo + int'($unsigned($random(seed)) % n);
  endfunction

  // high clocks per period; duty at or past the period means always active
  function automatic int pwm_high(int pe, int dv, logic [1:0] pa, logic lvl, logic inv);
    int h;
    h = (dv >= pe) ? pe : dv;
    if (pa != PA_WAVE) begin
      h = (pa == PA_HIGH) ? pe : 0;
    end else if (!lvl) begin
      h = pe - h;
    end
    return inv ? pe - h : h;
  endfunction

  // capture a minus capture b after rise, fall, rise, fall
  function automatic int cap_diff(int cc, int w, int gp);
    return (cc == 1) ? gp : (cc == 2) ? -w : gp - w;
  endfunction

  // one pwm run, window of k periods; period register 0 means 65536
  task automatic pwm(input int pr, input int dv, input logic [1:0] pa, input logic lvl, input logic inv,
                     input logic ccs, input int k);
    int pe;
    int h;
    pe = (pr == 0) ? 65536 : pr;
    c = cw(MODE_PWM, pa, lvl, inv, 1'b0, ccs, CLR_NONE, 1'b0);
    acc(1, OFF_CTRL, c);
    acc(1, OFF_PER, pr);
    acc(1, OFF_DUTY, dv);
    acc(1, OFF_STAT, 32'h3);
    acc(1, OFF_CTRL, c | 32'h1);
    repeat (6) @(posedge pclk);
    cnt_pin(k * pe, h);
    chk("pwm_high", h, k * pwm_high(pe, dv, pa, lvl, inv));
    chk("pwm_oe", pin_oe_n, 0);
    acc(0, OFF_STAT, 0);
    chk("pwm_flags", rv[1:0], {1'b1, dv != 0 && dv <= pe});
  endtask

  // one single pulse, started by software or by the trigger pin
  task automatic pulse(input int dv, input logic trg, output int w);
    c = cw(MODE_PWM, PA_PULSE, 1'b1, 1'b0, 1'b0, 1'b1, CLR_NONE, trg);
    acc(1, OFF_CTRL, c);
    acc(1, OFF_DUTY, dv);
    acc(1, OFF_STAT, 32'h3);
    fork
      if (trg) pin_partner_inst.drive(1, 1, 3); else acc(1, OFF_CTRL, c | 32'h1);
      cnt_pin(dv + 30, w);
    join
    if (trg) begin
      pin_partner_inst.drive(1, 0, 2);
    end
    acc(0, OFF_CTRL, 0);
    chk("sp_run_clr", rv[0], 0);
    acc(0, OFF_STAT, 0);
    chk("sp_duty_flag", rv[0], 1);
    acc(0, OFF_CNT, 0);
    a = rv;
    acc(0, OFF_CNT, 0);
    chk("sp_cnt_hold", rv, a);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    bad_count = 0;
    checked = 0;
    seed = 55490;
    offs = '{OFF_CTRL, OFF_STAT, OFF_CNT, OFF_DUTY, OFF_CAPB, OFF_PER};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, readback of the value registers, refused accesses
    foreach (offs[i]) begin
      acc(0, offs[i], 0);
      chk("reset_val", rv, 0);
    end
    for (int i = 3; i < 6; i++) begin
      bv = $random(seed);
      acc(1, offs[i], bv);
      acc(0, offs[i], 0);
      chk("readback", rv, {16'h0, bv[15:0]});
    end
    acc(1, 8'h18, 32'hffff_ffff);
    chk("unmapped_err", re, 1);
    acc(0, 8'h18, 0);
    chk("unmapped_data", rv, 0);
    acc(1, OFF_CNT, 32'h1234);
    acc(0, OFF_CNT, 0);
    chk("cnt_ro", rv, 0);
    // plain timer: compare-mode flags and clearing, pin released
    for (int s = 0; s < 2; s++) begin
      c = cw(MODE_TMR, PA_WAVE, 1'b1, 1'b0, 1'b0, s[0], CLR_NONE, 1'b0);
      acc(1, OFF_CTRL, c);
      acc(1, OFF_PER, 6);
      acc(1, OFF_DUTY, 3);
      acc(1, OFF_STAT, 32'h7);
      acc(1, OFF_CTRL, c | 32'h1);
      repeat (20) @(posedge pclk);
      acc(0, OFF_STAT, 0);
      chk("tmr_flags", rv[1:0], s ? 1 : 3);
      chk("tmr_oe", pin_oe_n, 1);
    end
    // pwm: levels, invert, forced pins, clear select, full-duty corner
    for (int i = 0; i < 8; i++) begin
      p = rnd(3, 10);
      d = (i == 5) ? p : rnd(0, p + 3);
      pwm(p, d, (i == 6) ? PA_LOW : (i == 7) ? PA_HIGH : PA_WAVE, i[0], i[1], i[2], 4);
    end
    pwm(0, 32'h8000, PA_WAVE, 1'b1, 1'b0, 1'b0, 1);
    // single pulse: width follows duty, trigger pin, period ignored
    acc(1, OFF_PER, 1);
    d = rnd(2, 20);
    p = d + rnd(1, 20);
    pulse(d, 1'b0, w1);
    pulse(p, 1'b0, w2);
    chk("sp_width", w2 - w1, p - d);
    pulse(d, 1'b1, w3);
    chk("sp_ext", w3, w1);
    acc(1, OFF_DUTY, 0);
    fork
      cnt_pin(60, w1);
      begin
        acc(1, OFF_CTRL, c | 32'h1);
        acc(1, OFF_CTRL, c);
      end
    join
    chk("sp_sw_end", w1 < 20, 1);
    // capture: clear field routes and clears, edges two clocks or wider
    for (int cc = 0; cc < 4; cc++) begin
      wd = rnd(3, 15);
      g = rnd(3, 15);
      bv = $random(seed);
      c = cw(MODE_CAP, EDGE_BOTH, 1'b0, 1'b0, 1'b0, 1'b0, cc[1:0], 1'b0);
      acc(1, OFF_CTRL, c);
      acc(1, OFF_PER, 0);
      acc(1, OFF_CAPB, bv);
      acc(1, OFF_CTRL, c | 32'h1);
      pin_partner_inst.drive(0, 1, wd);
      pin_partner_inst.drive(0, 0, g);
      pin_partner_inst.drive(0, 1, wd);
      pin_partner_inst.drive(0, 0, 4);
      acc(0, OFF_DUTY, 0);
      a = rv;
      acc(0, OFF_CAPB, 0);
      if (cc == 0) begin
        chk("cap_b_keep", rv, {16'h0, bv[15:0]});
      end else begin
        chk("cap_diff", {16'h0, a[15:0] - rv[15:0]}, {16'h0, 16'(cap_diff(cc, wd, g))});
        acc(0, OFF_STAT, 0);
        chk("cap_edge_flag", rv[2], 0);
      end
    end
    // capture: every edge code, both sources, period clear
    for (int e = 0; e < 4; e++) begin
      p = rnd(8, 5);
      c = cw(MODE_CAP, e[1:0], 1'b0, 1'b0, e[0], 1'b0, CLR_RISE, 1'b0);
      acc(1, OFF_CTRL, c);
      acc(1, OFF_PER, p);
      acc(1, OFF_STAT, 32'h7);
      acc(1, OFF_CTRL, c | 32'h1);
      pin_partner_inst.drive(!e[0], 1, 3);
      pin_partner_inst.drive(!e[0], 0, 3);
      acc(0, OFF_STAT, 0);
      chk("cap_other_pin", rv[0], 0);
      pin_partner_inst.drive(e[0], 1, 4);
      acc(0, OFF_STAT, 0);
      chk("cap_rise", rv[0], e == 0 || e == 2);
      if (e == 0 || e == 2) begin
        chk("cap_rise_flag", rv[2], 1);
      end
      acc(1, OFF_STAT, 32'h1);
      pin_partner_inst.drive(e[0], 0, 4);
      acc(0, OFF_STAT, 0);
      chk("cap_fall", rv[0], e == 1 || e == 2);
      chk("cap_per_flag", rv[1], 1);
      acc(0, OFF_CNT, 0);
      chk("cap_cnt_max", rv < p, 1);
    end
    test_done();
  end
endmodule
